// ===== core/tmr_channel.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tmr_channel
	import tmr_pkg::*;
#(
	parameter int unsigned CHAN_IDX = 0
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic [TMR_ADDR_W-1:0] reg_addr,
	input  wire logic [TMR_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [TMR_DATA_W-1:0] reg_rdata,
	input  wire logic                  timer_event_input_pin,
	input  wire logic                  subclock_div32_source,
	input  wire logic                  group_b_third_timer_ovf,
	input  wire logic                  neighbour_group_a_timer_ovf,
	input  wire logic                  timer_toggle_output_pin_in,
	output logic                       timer_toggle_output_pin_out,
	output logic                       timer_toggle_output_pin_oe,
	output logic                       irq_req,
	output logic                       count_ovf
);
	if (CHAN_IDX > TMR_CHAN_MAX) begin : g_bad_chan
		$error("tmr_channel: CHAN_IDX out of range");
	end

	// two-phase capability is reported only; this channel counts single-phase
	localparam logic TWO_PHASE_CAP = (CHAN_IDX >= TMR_TWO_PH_FIRST);

	logic [TMR_DATA_W-1:0]  count;
	logic [TMR_DATA_W-1:0]  reload;
	logic [TMR_DATA_W-1:0]  mode_reg;
	logic                   start_flag;
	logic [TMR_PRESC_W-1:0] presc;
	logic [TMR_DATA_W-1:0]  next_count;
	logic [TMR_DATA_W-1:0]  rd_mux;
	logic [TMR_DATA_W-1:0]  status_word;

	logic       in_lvl;
	logic       in_rise;
	logic       in_fall;
	logic       sub_rise;
	logic       dir_pin_lvl;
	tmr_mode_e  mode;
	tmr_cksel_e cksel;
	tmr_evsrc_e evsrc;

	wire hit_count  = (reg_addr == TMR_OFF_COUNT);
	wire hit_mode   = (reg_addr == TMR_OFF_MODE);
	wire hit_start  = (reg_addr == TMR_OFF_START);
	wire hit_status = (reg_addr == TMR_OFF_STATUS);
	wire wr_count   = reg_wr & hit_count;
	wire wr_mode    = reg_wr & hit_mode;
	wire wr_start   = reg_wr & hit_start;

	function automatic logic [1:0] field2(input logic [TMR_DATA_W-1:0] r, input int unsigned lsb);
		field2 = r[lsb +: 2];
	endfunction : field2

	function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
		input logic c, input logic d);
		case (sel)
			2'h0: pick4 = a;
			2'h1: pick4 = b;
			2'h2: pick4 = c;
			default: pick4 = d;
		endcase
	endfunction : pick4

	assign mode  = tmr_mode_e'(field2(mode_reg, TMR_MODE_LSB));
	assign cksel = tmr_cksel_e'(field2(mode_reg, TMR_CKSEL_LSB));
	assign evsrc = tmr_evsrc_e'(field2(mode_reg, TMR_EVSRC_LSB));

	wire gate_en   = mode_reg[TMR_GATE_EN_BIT];
	wire gate_hi   = mode_reg[TMR_GATE_HI_BIT];
	wire pulse_en  = mode_reg[TMR_PULSE_BIT];
	wire edge_fall = mode_reg[TMR_FALL_BIT];
	wire dir_pin   = mode_reg[TMR_DIR_PIN_BIT];
	wire dir_sw_up = mode_reg[TMR_DIR_UP_BIT];
	wire free_run  = mode_reg[TMR_FREE_BIT];
	wire is_timer  = (mode == TMR_MODE_TIMER);
	wire is_event  = (mode == TMR_MODE_EVENT);

	tmr_sync_edge u_in_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       (timer_event_input_pin),
		.lvl     (in_lvl),
		.rise    (in_rise),
		.fall    (in_fall)
	);

	tmr_sync_edge u_sub_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       (subclock_div32_source),
		.lvl     (),
		.rise    (sub_rise),
		.fall    ()
	);

	tmr_sync_edge u_dir_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.d       (timer_toggle_output_pin_in),
		.lvl     (dir_pin_lvl),
		.rise    (),
		.fall    ()
	);

	// free-running prescaler shared by the divide-by-8 and divide-by-32 sources; the subclock source does not use it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			presc <= '0;
		else
			presc <= presc + 1'b1;
	end

	wire div8_tick  = (presc[2:0] == TMR_DIV8_LAST[2:0]);
	wire div32_tick = (presc == TMR_DIV32_LAST);
	wire clk_tick   = pick4(cksel, 1'b1, div8_tick, div32_tick, sub_rise);

	// gate level only gates counting in timer mode; in event mode the pin can supply the counted edges
	wire gate_ok    = ~gate_en | (in_lvl == gate_hi);
	wire pin_edge   = edge_fall ? in_fall : in_rise;
	wire ev_tick    = pick4(evsrc, pin_edge, group_b_third_timer_ovf,
		neighbour_group_a_timer_ovf, 1'b0);
	// the pin cannot drive pulses and sense direction at once; pulse wins
	wire use_dir_pin = dir_pin & ~pulse_en;
	wire dir_up      = use_dir_pin ? dir_pin_lvl : dir_sw_up;

	wire tick_timer = is_timer & gate_ok & clk_tick;
	wire tick_event = is_event & ev_tick;
	wire tick       = start_flag & (tick_timer | tick_event);
	wire count_up   = is_event & dir_up;
	wire wrap_hit   = count_up ? (count == TMR_CNT_MAX) : (count == TMR_CNT_MIN);
	wire wrap_evt   = tick & wrap_hit;
	wire do_reload  = wrap_evt & ~(is_event & free_run);
	wire load_both  = wr_count & ~start_flag;

	// reload on wrap gives n+1 ticks down, FFFF-n+1 ticks up
	assign next_count = load_both ? reg_wdata :
		do_reload ? reload :
		(tick & count_up) ? count + 1'b1 :
		tick ? count - 1'b1 : count;

	assign status_word = {12'h000, TWO_PHASE_CAP, timer_toggle_output_pin_out, dir_up,
		start_flag & (is_event | gate_ok)};

	assign rd_mux = hit_count  ? count :
		hit_mode   ? mode_reg :
		hit_start  ? {15'h0000, start_flag} :
		hit_status ? status_word : '0;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			count <= TMR_COUNT_RST;
		else
			count <= next_count;
	end

	// a running write lands in reload and waits for the next wrap
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			reload <= TMR_COUNT_RST;
		else if (wr_count)
			reload <= reg_wdata;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg   <= TMR_MODE_RST;
			start_flag <= 1'b0;
		end else begin
			if (wr_mode)
				mode_reg <= reg_wdata & TMR_MODE_MASK;
			if (wr_start)
				start_flag <= reg_wdata[0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_mux : '0;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_req   <= 1'b0;
			count_ovf <= 1'b0;
		end else begin
			irq_req   <= wrap_evt;
			count_ovf <= wrap_evt;
		end
	end

	wire pulse_active = pulse_en & (is_timer | is_event);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_toggle_output_pin_out <= 1'b0;
			timer_toggle_output_pin_oe  <= 1'b0;
		end else begin
			timer_toggle_output_pin_oe <= pulse_active;
			if (pulse_active & wrap_evt)
				timer_toggle_output_pin_out <= ~timer_toggle_output_pin_out;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_timer_underflow;
		is_timer && tick && count == TMR_CNT_MIN;
	endsequence

	sequence s_event_up_wrap;
		is_event && tick && count_up && count == TMR_CNT_MAX;
	endsequence

	sequence s_event_down_wrap;
		is_event && tick && !count_up && count == TMR_CNT_MIN;
	endsequence

	sequence s_event_step;
		is_event && tick && !wrap_hit && !wr_count;
	endsequence

	chk_timer_reload_load: assert property (
		s_timer_underflow and (!wr_count) |=> count == $past(reload))
		else $error("timer underflow did not load reload value");

	chk_timer_count_down: assert property (
		is_timer && tick && count != TMR_CNT_MIN && !wr_count |=> count == $past(count) - 16'h0001)
		else $error("timer did not count down by one");

	chk_div8_spacing: assert property (
		is_timer && cksel == TMR_CK_DIV8 && clk_tick
			|=> (cksel != TMR_CK_DIV8 || !clk_tick) [*7] ##1 (cksel != TMR_CK_DIV8 || clk_tick))
		else $error("divide-by-8 source not spaced by eight clocks");

	chk_stop_holds: assert property (
		!start_flag && !wr_count |=> count == $past(count))
		else $error("counter moved while stopped");

	chk_irq_on_wrap: assert property (
		wrap_evt |=> irq_req ##1 (!irq_req || $past(wrap_evt)))
		else $error("interrupt request not a pulse after wrap");

	chk_irq_cause: assert property (
		irq_req |-> $past(wrap_evt))
		else $error("interrupt request without wrap");

	chk_read_live: assert property (
		reg_rd && hit_count |=> reg_rdata == $past(count))
		else $error("timer read not the live count");

	chk_write_stopped: assert property (
		wr_count && !start_flag |=> count == $past(reg_wdata) && reload == $past(reg_wdata))
		else $error("stopped write did not load both");

	chk_write_running: assert property (
		wr_count && start_flag && !tick |=> count == $past(count) && reload == $past(reg_wdata))
		else $error("running write disturbed the counter");

	chk_gate_blocks: assert property (
		is_timer && gate_en && (in_lvl != gate_hi) && !wr_count |=> count == $past(count))
		else $error("counter moved with gate closed");

	chk_pulse_toggle: assert property (
		wrap_evt && pulse_active |=> timer_toggle_output_pin_out != $past(timer_toggle_output_pin_out))
		else $error("pulse output did not toggle on wrap");

	chk_pulse_steady: assert property (
		!wrap_evt |=> timer_toggle_output_pin_out == $past(timer_toggle_output_pin_out))
		else $error("pulse output toggled without wrap");

	chk_edge_count: assert property (
		start_flag && is_event && evsrc == TMR_EV_PIN && !pin_edge && !wr_count
			|=> count == $past(count))
		else $error("event counter moved without an edge");

	chk_groupb_count: assert property (
		start_flag && is_event && evsrc == TMR_EV_GROUPB && group_b_third_timer_ovf
			&& !wrap_hit && !wr_count && count_up |=> count == $past(count) + 16'h0001)
		else $error("group b overflow not counted");

	chk_dir_pin: assert property (
		s_event_step and (use_dir_pin)
			|=> count == ($past(dir_pin_lvl) ? $past(count) + 16'h0001 : $past(count) - 16'h0001))
		else $error("count direction does not follow pin");

	chk_event_up_reload: assert property (
		s_event_up_wrap and (!free_run && !wr_count) |=> count == $past(reload))
		else $error("up overflow did not reload");

	chk_event_down_reload: assert property (
		s_event_down_wrap and (!free_run && !wr_count) |=> count == $past(reload))
		else $error("down underflow did not reload");

	chk_free_run_wrap: assert property (
		s_event_up_wrap and (free_run && !wr_count) |=> count == TMR_CNT_MIN)
		else $error("free-run did not wrap to zero");

	chk_oe_follows: assert property (
		timer_toggle_output_pin_oe |-> $past(pulse_active))
		else $error("output enabled without pulse function");

	chk_sync_edge: assert property (
		(in_rise || in_fall) |-> in_lvl == $past(timer_event_input_pin, 2))
		else $error("input edge not two clocks behind the pin");

	chk_event_down_step: assert property (
		s_event_step and (!count_up) |=> count == $past(count) - 16'h0001)
		else $error("event counter did not count down by one");

	chk_event_up_step: assert property (
		s_event_step and (count_up) |=> count == $past(count) + 16'h0001)
		else $error("event counter did not count up by one");

	chk_free_down_wrap: assert property (
		s_event_down_wrap and (free_run && !wr_count) |=> count == TMR_CNT_MAX)
		else $error("free-run did not wrap to all ones");

	chk_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data stood without a read");

	chk_other_mode_hold: assert property (
		!is_timer && !is_event && !wr_count |=> count == $past(count))
		else $error("counter moved outside timer and event modes");

	chk_oe_on_pulse: assert property (
		pulse_active |=> timer_toggle_output_pin_oe)
		else $error("pulse function without output enable");

	chk_reserved_zero: assert property (
		wr_mode |=> mode_reg[15:13] == 3'h0)
		else $error("reserved mode bits stored");
endmodule : tmr_channel
`default_nettype wire

// ===== core/tmr_pkg.sv
package tmr_pkg;
	localparam int unsigned TMR_DATA_W       = 16;
	localparam int unsigned TMR_ADDR_W       = 4;
	localparam int unsigned TMR_PRESC_W      = 5;
	localparam int unsigned TMR_CHAN_MAX     = 4;
	localparam int unsigned TMR_TWO_PH_FIRST = 2;

	localparam logic [3:0] TMR_OFF_COUNT  = 4'h0;
	localparam logic [3:0] TMR_OFF_MODE   = 4'h4;
	localparam logic [3:0] TMR_OFF_START  = 4'h8;
	localparam logic [3:0] TMR_OFF_STATUS = 4'hc;

	localparam int unsigned TMR_MODE_LSB    = 0;
	localparam int unsigned TMR_CKSEL_LSB   = 2;
	localparam int unsigned TMR_GATE_EN_BIT = 4;
	localparam int unsigned TMR_GATE_HI_BIT = 5;
	localparam int unsigned TMR_PULSE_BIT   = 6;
	localparam int unsigned TMR_FALL_BIT    = 7;
	localparam int unsigned TMR_EVSRC_LSB   = 8;
	localparam int unsigned TMR_DIR_PIN_BIT = 10;
	localparam int unsigned TMR_DIR_UP_BIT  = 11;
	localparam int unsigned TMR_FREE_BIT    = 12;
	localparam logic [15:0] TMR_MODE_MASK   = 16'h1fff;

	localparam logic [15:0] TMR_MODE_RST  = 16'h0000;
	localparam logic [15:0] TMR_COUNT_RST = 16'h0000;
	localparam logic [15:0] TMR_CNT_MAX   = 16'hffff;
	localparam logic [15:0] TMR_CNT_MIN   = 16'h0000;
	localparam logic [4:0]  TMR_DIV8_LAST  = 5'h07;
	localparam logic [4:0]  TMR_DIV32_LAST = 5'h1f;

	typedef enum logic [1:0] {TMR_MODE_TIMER, TMR_MODE_EVENT, TMR_MODE_ONESHOT, TMR_MODE_PWM} tmr_mode_e;
	typedef enum logic [1:0] {TMR_CK_DIV1, TMR_CK_DIV8, TMR_CK_DIV32, TMR_CK_SUB32} tmr_cksel_e;
	typedef enum logic [1:0] {TMR_EV_PIN, TMR_EV_GROUPB, TMR_EV_NEIGHBOUR, TMR_EV_NONE} tmr_evsrc_e;
endpackage : tmr_pkg

// ===== core/tmr_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_sync_edge (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic d,
	output logic      lvl,
	output logic      rise,
	output logic      fall
);
	logic meta;
	logic sync;
	logic prev;

	// meta feeds sync only; edges come from the settled pair
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= d;
			sync <= meta;
			prev <= sync;
		end
	end

	assign lvl  = sync;
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;
endmodule : tmr_sync_edge
`default_nettype wire

// ===== verif/tmr_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_pulse_src (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic pin_hold,
	input  wire logic pin_req,
	input  wire logic gb_req,
	input  wire logic nb_req,
	input  wire logic dir_up,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      timer_event_input_pin,
	output logic      subclock_div32_source,
	output logic      group_b_third_timer_ovf,
	output logic      neighbour_group_a_timer_ovf,
	output logic      pin_level
);
	logic [2:0] pin_cnt;
	logic [1:0] sub_cnt;
	// four cycles high so a two-stage sync never misses a pulse
	assign timer_event_input_pin = pin_hold | (pin_cnt != 3'h0);
	// shared pin: the block wins while it drives, else the direction source
	assign pin_level = pin_oe ? pin_out : dir_up;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_cnt <= 3'h0;
			sub_cnt <= 2'h0;
			subclock_div32_source <= 1'b0;
			group_b_third_timer_ovf <= 1'b0;
			neighbour_group_a_timer_ovf <= 1'b0;
		end else begin
			if (pin_req)
				pin_cnt <= 3'h4;
			else if (pin_cnt != 3'h0)
				pin_cnt <= pin_cnt - 3'h1;
			sub_cnt <= sub_cnt + 2'h1;
			subclock_div32_source <= subclock_div32_source ^ (sub_cnt == 2'h3);
			group_b_third_timer_ovf <= gb_req;
			neighbour_group_a_timer_ovf <= nb_req;
		end
	end
endmodule : tmr_pulse_src
`default_nettype wire

// ===== verif/sixteen_bit_timer_event_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_event_counter_bench import tmr_pkg::*;;
	typedef struct packed {logic [15:0] mode; logic [15:0] n; int src; int k; logic [15:0] cnt; logic [15:0] exp;} tmr_row_s;
	logic                  sys_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic [TMR_ADDR_W-1:0] reg_addr = '0;
	logic [TMR_DATA_W-1:0] reg_wdata = '0;
	logic                  reg_wr = 1'b0;
	logic                  reg_rd = 1'b0;
	logic [TMR_DATA_W-1:0] reg_rdata;
	logic                  pin_hold = 1'b0;
	logic                  pin_req = 1'b0;
	logic                  gb_req = 1'b0;
	logic                  nb_req = 1'b0;
	logic                  dir_up = 1'b1;
	logic                  ev_pin, sub_src, gb_ovf, nb_ovf, pin_level, pin_out, pin_oe, irq_req, count_ovf;
	int                    err_count = 0;
	int                    samples_checked = 0;
	int                    irq_total = 0;
	// src 3 marks a timer row: exp is the irq spacing, else the irq count
	tmr_row_s rows [13] = '{
		'{16'h0000, 16'h0002, 3, 0, 16'h0000, 16'h0003}, '{16'h0004, 16'h0000, 3, 0, 16'h0000, 16'h0008},
		'{16'h0008, 16'h0001, 3, 0, 16'h0000, 16'h0040}, '{16'h000c, 16'h0001, 3, 0, 16'h0000, 16'h0010},
		'{16'h0040, 16'h0001, 3, 0, 16'h0000, 16'h0002}, '{16'h0801, 16'hfffd, 0, 3, 16'hfffd, 16'h0001},
		'{16'h0881, 16'hfffe, 0, 2, 16'hfffe, 16'h0001}, '{16'h0101, 16'h0001, 1, 2, 16'h0001, 16'h0001},
		'{16'h0201, 16'h0002, 2, 2, 16'h0000, 16'h0000}, '{16'h1801, 16'hfffe, 0, 3, 16'h0001, 16'h0001},
		'{16'h1101, 16'h0001, 1, 3, 16'hfffe, 16'h0001}, '{16'h0501, 16'h0005, 1, 2, 16'h0007, 16'h0000},
		'{16'h0141, 16'h0000, 1, 1, 16'h0000, 16'h0001}};

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (irq_req === 1'b1) irq_total++;

	tmr_channel #(.CHAN_IDX(0)) tmr_channel_inst (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_event_input_pin(ev_pin), .subclock_div32_source(sub_src), .group_b_third_timer_ovf(gb_ovf),
		.neighbour_group_a_timer_ovf(nb_ovf), .timer_toggle_output_pin_in(pin_level),
		.timer_toggle_output_pin_out(pin_out), .timer_toggle_output_pin_oe(pin_oe), .irq_req(irq_req),
		.count_ovf(count_ovf));
	tmr_pulse_src tmr_pulse_src_inst (.sys_clk(sys_clk), .rst_b(rst_b), .pin_hold(pin_hold), .pin_req(pin_req),
		.gb_req(gb_req), .nb_req(nb_req), .dir_up(dir_up), .pin_out(pin_out), .pin_oe(pin_oe),
		.timer_event_input_pin(ev_pin), .subclock_div32_source(sub_src), .group_b_third_timer_ovf(gb_ovf),
		.neighbour_group_a_timer_ovf(nb_ovf), .pin_level(pin_level));

	task automatic end_sim();
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [TMR_ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [TMR_ADDR_W-1:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// two reads two edges apart: a running count drops by two
	task automatic delta(output logic [15:0] d);
		logic [15:0] r1, r2;
		rd(TMR_OFF_COUNT, r1);
		rd(TMR_OFF_COUNT, r2);
		d = r1 - r2;
	endtask : delta

	task automatic setup(input logic [15:0] mode, input logic [15:0] n);
		wr(TMR_OFF_START, 16'h0000);
		wr(TMR_OFF_MODE, mode);
		wr(TMR_OFF_COUNT, n);
		wr(TMR_OFF_START, 16'h0001);
	endtask : setup

	task automatic irq_gap(output int gap, output logic tog);
		int i;
		logic o1;
		for (i = 0; i < 300 && irq_req !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		o1 = pin_out;
		check({15'h0, count_ovf}, 16'h0001);
		gap = 0;
		do begin
			@(posedge sys_clk);
			#1;
			gap++;
		end while (irq_req !== 1'b1 && gap < 300);
		tog = o1 ^ pin_out;
		if (i >= 300 || gap >= 300) begin
			err_count++;
			end_sim();
		end
	endtask : irq_gap

	task automatic events(input int src, input int k);
		for (int j = 0; j < k; j++) begin
			@(posedge sys_clk);
			case (src)
				0: pin_req <= 1'b1;
				1: gb_req <= 1'b1;
				default: nb_req <= 1'b1;
			endcase
			@(posedge sys_clk);
			pin_req <= 1'b0;
			gb_req <= 1'b0;
			nb_req <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
	endtask : events

	initial begin
		int gap, base;
		logic tog, o0;
		logic [15:0] v;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			setup(rows[i].mode, rows[i].n);
			if (rows[i].src == 3) begin
				irq_gap(gap, tog);
				check(16'(gap), rows[i].exp);
				check({15'h0, tog}, {15'h0, rows[i].mode[6]});
			end else begin
				base = irq_total;
				o0 = pin_out;
				events(rows[i].src, rows[i].k);
				repeat (6) @(posedge sys_clk);
				rd(TMR_OFF_COUNT, v);
				check(v, rows[i].cnt);
				check(16'(irq_total - base), rows[i].exp);
				check({15'h0, pin_out}, {15'h0, o0 ^ rows[i].mode[6]});
			end
			check({15'h0, pin_oe}, {15'h0, rows[i].mode[6]});
		end
		wr(TMR_OFF_START, 16'h0000);
		wr(TMR_OFF_COUNT, 16'h1234);
		rd(TMR_OFF_COUNT, v);
		check(v, 16'h1234);
		wr(TMR_OFF_MODE, 16'hffff);
		rd(TMR_OFF_MODE, v);
		check(v, TMR_MODE_MASK);
		wr(4'h2, 16'h5555);
		rd(4'h2, v);
		check(v, 16'h0000);
		rd(TMR_OFF_STATUS, v);
		check(v & 16'h0008, 16'h0000);
		setup(16'h0000, 16'hffff);
		delta(v);
		check(v, 16'h0002);
		wr(TMR_OFF_START, 16'h0000);
		delta(v);
		check(v, 16'h0000);
		setup(16'h0030, 16'hffff);
		delta(v);
		check(v, 16'h0000);
		pin_hold <= 1'b1;
		repeat (4) @(posedge sys_clk);
		delta(v);
		check(v, 16'h0002);
		setup(16'h0010, 16'hffff);
		delta(v);
		check(v, 16'h0000);
		setup(16'h0000, 16'h0002);
		wr(TMR_OFF_COUNT, 16'h0004);
		irq_gap(gap, tog);
		irq_gap(gap, tog);
		check(16'(gap), 16'h0005);
		dir_up <= 1'b0;
		setup(16'h0501, 16'h0005);
		events(1, 2);
		rd(TMR_OFF_COUNT, v);
		check(v, 16'h0003);
		dir_up <= 1'b1;
		setup(16'h0301, 16'h0005);
		events(1, 1);
		rd(TMR_OFF_COUNT, v);
		check(v, 16'h0005);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		#1;
		check({13'h0, irq_req, pin_oe, pin_out}, 16'h0000);
		@(posedge sys_clk);
		rst_b <= 1'b1;
		rd(TMR_OFF_COUNT, v);
		check(v, TMR_COUNT_RST);
		rd(TMR_OFF_MODE, v);
		check(v, TMR_MODE_RST);
		end_sim();
	end
endmodule : sixteen_bit_timer_event_counter_bench
`default_nettype wire
